// ### include/addr_map.svh
`ifndef ADDR_MAP_SVH
`define ADDR_MAP_SVH
// every peripheral window spans 4 KB from its base, except the timer, which spans 12 KB up to TIMER_LAST
`define WIN_4K_LAST 32'h0000_0fff
// memory regions
`define FLASH_BASE 32'h0000_0000
`define FLASH_LAST 32'h0000_7fff
`define SRAM_BASE 32'h2000_0000
`define SRAM_LAST 32'h2000_1fff
`define SRAM_ALIAS_BASE 32'h2200_0000
`define SRAM_ALIAS_LAST 32'h2203_ffff
// peripheral space, its bit-band alias and its never-execute span
`define PERI_BASE 32'h4000_0000
`define PERI_BB_LAST 32'h400f_ffff
`define PERI_ALIAS_BASE 32'h4200_0000
`define PERI_ALIAS_LAST 32'h43ff_ffff
`define PERI_NOEXEC_LAST 32'h5fff_ffff
// peripheral windows
`define WDOG_BASE 32'h4000_0000
`define GPIOA_BASE 32'h4000_4000
`define GPIOB_BASE 32'h4000_5000
`define GPIOC_BASE 32'h4000_6000
`define GPIOD_BASE 32'h4000_7000
`define SSI0_BASE 32'h4000_8000
`define UART0_BASE 32'h4000_c000
`define UART1_BASE 32'h4000_d000
`define I2C0_BASE 32'h4002_0000
`define GPIOE_BASE 32'h4002_4000
`define PWM_BASE 32'h4002_8000
`define TIMER_BASE 32'h4003_0000
`define TIMER_LAST 32'h4003_2fff
`define ADC0_BASE 32'h4003_8000
`define FLASHCTL_BASE 32'h400f_d000
`define SYSCTL_BASE 32'h400f_e000
// private core bus windows
`define INSTR_TRACE_BASE 32'he000_0000
`define DATA_WATCH_BASE 32'he000_1000
`define FLASH_PATCH_BASE 32'he000_2000
`define CORE_PERIPH_BASE 32'he000_e000
`define TRACE_PORT_BASE 32'he004_0000
`endif

// ### include/addr_dec_pkg.sv
package addr_dec_pkg;
  // slave select index, one bit of the select vector each
  typedef enum logic [4:0] {
    TGT_FLASH = 5'h00, TGT_SRAM = 5'h01, TGT_WDOG = 5'h02, TGT_GPIOA = 5'h03,
    TGT_GPIOB = 5'h04, TGT_GPIOC = 5'h05, TGT_GPIOD = 5'h06, TGT_GPIOE = 5'h07,
    TGT_FLASHCTL = 5'h08, TGT_SYSCTL = 5'h09, TGT_INSTR_TRACE = 5'h0a,
    TGT_DATA_WATCH = 5'h0b, TGT_FLASH_PATCH = 5'h0c, TGT_CORE_PERIPH = 5'h0d,
    TGT_TRACE_PORT = 5'h0e, TGT_MISC_PERIPH = 5'h0f
  } target_e;
  localparam int unsigned NumTargets = 16;
  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0, SIZE_HALF = 2'h1, SIZE_WORD = 2'h2
  } size_e;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_ACCESS = 4'h2, ST_BB_READ = 4'h4, ST_BB_WRITE = 4'h8
  } state_e;
endpackage

// ### design/lane_steer.sv
`timescale 1ns/1ns
`default_nettype none
module lane_steer (
  // request lanes
  input wire logic [1:0] addrLow,
  input wire addr_dec_pkg::size_e size,
  input wire logic [31:0] wdataIn,
  // steered lanes
  output logic [3:0] byteEn,
  output logic [31:0] laneData,
  output logic misaligned
);
  import addr_dec_pkg::*;

  // write data arrives right-justified and is copied onto every lane
  always_comb begin
    byteEn = 4'h0;
    laneData = wdataIn;
    misaligned = 1'b0;
    case (size)
      SIZE_BYTE: begin // [RULE17] [RULE18]
        byteEn = 4'h1 << addrLow;
        laneData = {4{wdataIn[7:0]}};
      end
      SIZE_HALF: begin // [RULE17] [RULE18]
        byteEn = 4'h3 << addrLow;
        laneData = {2{wdataIn[15:0]}};
        misaligned = addrLow[0];
      end
      SIZE_WORD: begin // [RULE17]
        byteEn = 4'hf;
        misaligned = |addrLow;
      end
      default: misaligned = 1'b1;
    endcase
  end
endmodule
`default_nettype wire

// ### design/region_decoder.sv
`include "addr_map.svh"
`timescale 1ns/1ns
`default_nettype none
module region_decoder (
  // address to decode
  input wire logic [31:0] addr,
  // decode result
  output addr_dec_pkg::target_e target,
  output logic hit
);
  import addr_dec_pkg::*;

  localparam int NumWin = 22;
  // fixed table, nothing here can be moved at run time [RULE1]
  localparam logic [31:0] WinFirst [NumWin] = '{
    `FLASH_BASE, `SRAM_BASE, `WDOG_BASE, `GPIOA_BASE, `GPIOB_BASE,
    `GPIOC_BASE, `GPIOD_BASE, `SSI0_BASE, `UART0_BASE, `UART1_BASE,
    `I2C0_BASE, `GPIOE_BASE, `PWM_BASE, `TIMER_BASE, `ADC0_BASE,
    `FLASHCTL_BASE, `SYSCTL_BASE, `INSTR_TRACE_BASE, `DATA_WATCH_BASE,
    `FLASH_PATCH_BASE, `CORE_PERIPH_BASE, `TRACE_PORT_BASE};
  localparam logic [31:0] WinLast [NumWin] = '{
    `FLASH_LAST, `SRAM_LAST, `WDOG_BASE + `WIN_4K_LAST,
    `GPIOA_BASE + `WIN_4K_LAST, `GPIOB_BASE + `WIN_4K_LAST,
    `GPIOC_BASE + `WIN_4K_LAST, `GPIOD_BASE + `WIN_4K_LAST,
    `SSI0_BASE + `WIN_4K_LAST, `UART0_BASE + `WIN_4K_LAST,
    `UART1_BASE + `WIN_4K_LAST, `I2C0_BASE + `WIN_4K_LAST,
    `GPIOE_BASE + `WIN_4K_LAST, `PWM_BASE + `WIN_4K_LAST, `TIMER_LAST,
    `ADC0_BASE + `WIN_4K_LAST, `FLASHCTL_BASE + `WIN_4K_LAST,
    `SYSCTL_BASE + `WIN_4K_LAST, `INSTR_TRACE_BASE + `WIN_4K_LAST,
    `DATA_WATCH_BASE + `WIN_4K_LAST, `FLASH_PATCH_BASE + `WIN_4K_LAST,
    `CORE_PERIPH_BASE + `WIN_4K_LAST, `TRACE_PORT_BASE + `WIN_4K_LAST};
  // [RULE3] [RULE4] [RULE8] [RULE9] [RULE10] [RULE11] [RULE12]
  // [RULE13] [RULE14] [RULE15]
  localparam logic [4:0] WinTgt [NumWin] = '{
    TGT_FLASH, TGT_SRAM, TGT_WDOG, TGT_GPIOA, TGT_GPIOB, TGT_GPIOC,
    TGT_GPIOD, TGT_MISC_PERIPH, TGT_MISC_PERIPH, TGT_MISC_PERIPH,
    TGT_MISC_PERIPH, TGT_GPIOE, TGT_MISC_PERIPH, TGT_MISC_PERIPH,
    TGT_MISC_PERIPH, TGT_FLASHCTL, TGT_SYSCTL, TGT_INSTR_TRACE,
    TGT_DATA_WATCH, TGT_FLASH_PATCH, TGT_CORE_PERIPH, TGT_TRACE_PORT};

  logic [NumWin-1:0] match;
  logic [4:0] tgtBits;

  for (genvar i = 0; i < NumWin; i++) begin : g_win
    assign match[i] = (addr >= WinFirst[i]) && (addr <= WinLast[i]);
  end

  // windows never overlap, so an or of the hit codes is the code
  always_comb begin
    tgtBits = 5'h00;
    for (int i = 0; i < NumWin; i++) begin
      if (match[i]) begin
        tgtBits = tgtBits | WinTgt[i];
      end
    end
  end

  assign target = target_e'(tgtBits);
  assign hit = |match; // [RULE2]
endmodule
`default_nettype wire

// ### design/sys_addr_decoder.sv
`include "addr_map.svh"
`timescale 1ns/1ns
`default_nettype none
// Function
// RULE1: one fixed 4 GB map, never remapped
// RULE2: reserved addresses answer with a fault
// RULE3: flash at 0x0000_0000 to 0x0000_7fff
// RULE4: SRAM at 0x2000_0000 to 0x2000_1fff
// RULE5: SRAM alias word maps one SRAM bit
// RULE6: peripheral alias covers 0x4000_0000 to 0x400f_ffff
// RULE7: alias access changes one bit atomically
// RULE8: watchdog window at 0x4000_0000
// RULE9: GPIO A to D in consecutive windows
// RULE10: GPIO E window at 0x4002_4000
// RULE11: flash control window at 0x400f_d000
// RULE12: system control window at 0x400f_e000
// RULE13: trace, watchpoint, flash patch at 0xe000_0000
// RULE14: core peripherals at 0xe000_e000
// RULE15: trace port at 0xe004_0000, rest reserved
// RULE16: slave address is window base plus offset
// RULE17: byte, halfword and word sizes honoured
// RULE18: little-endian byte lanes
// RULE19: fetch from peripheral region faults
// RULE20: one select or fault, decoded combinationally
module sys_addr_decoder (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // master request
  input wire logic reqValid,
  input wire logic [31:0] reqAddr,
  input wire logic reqWrite,
  input wire addr_dec_pkg::size_e reqSize,
  input wire logic reqFetch,
  input wire logic [31:0] reqWdata,
  output logic reqReady_r,
  // master response
  output logic rspValid_r,
  output logic rspFault_r,
  output logic [31:0] rspData_r,
  // slave request
  output logic [addr_dec_pkg::NumTargets-1:0] slvSel_r,
  output logic slvValid_r,
  output logic [31:0] slvAddr_r,
  output logic slvWrite_r,
  output addr_dec_pkg::size_e slvSize_r,
  output logic [3:0] slvByteEn_r,
  output logic [31:0] slvWdata_r,
  output logic slvLock_r,
  // slave answer
  input wire logic slvReady,
  input wire logic [31:0] slvRdata
);
  import addr_dec_pkg::*;

  localparam logic [NumTargets-1:0] SelOne = {{(NumTargets-1){1'b0}}, 1'b1};

  state_e state_r;
  state_e state_nxt;
  logic take;
  logic inSramAlias;
  logic inPeriAlias;
  logic isAlias;
  logic inNoExec;
  logic misaligned;
  logic hit;
  logic fault;
  logic [31:0] aliasOff;
  logic [31:0] bbAddr;
  logic [31:0] effAddr;
  logic [31:0] laneData;
  logic [31:0] rdShift;
  logic [31:0] rdData;
  logic [3:0] byteEn;
  size_e effSize;
  target_e target;
  logic [2:0] bbBit_r;
  logic bbWrite_r;
  logic bbValue_r;
  logic [7:0] bbByte;
  logic [7:0] bbMod;

  assign take = reqValid && reqReady_r;

  // alias detection and translation to the bit's byte
  assign inSramAlias = (reqAddr >= `SRAM_ALIAS_BASE) && (reqAddr <= `SRAM_ALIAS_LAST);
  assign inPeriAlias = (reqAddr >= `PERI_ALIAS_BASE) && (reqAddr <= `PERI_ALIAS_LAST);
  assign isAlias = inSramAlias || inPeriAlias;
  assign aliasOff = inSramAlias ? reqAddr - `SRAM_ALIAS_BASE : reqAddr - `PERI_ALIAS_BASE;
  // each alias word is one bit, so 32 alias bytes stand for one byte [RULE5] [RULE6]
  assign bbAddr = (inSramAlias ? `SRAM_BASE : `PERI_BASE) + {5'h00, aliasOff[31:5]};
  assign effAddr = isAlias ? bbAddr : reqAddr;
  assign effSize = isAlias ? SIZE_BYTE : reqSize;

  // peripheral space holds device registers only, never code [RULE19]
  assign inNoExec = (reqAddr >= `PERI_BASE) && (reqAddr <= `PERI_NOEXEC_LAST);

  region_decoder region_decoder_inst (
    .addr(effAddr),
    .target(target),
    .hit(hit)
  );

  lane_steer lane_steer_inst (
    .addrLow(effAddr[1:0]),
    .size(effSize),
    .wdataIn(reqWdata),
    .byteEn(byteEn),
    .laneData(laneData),
    .misaligned(misaligned)
  );

  // decided in the same cycle the request is offered [RULE20] [RULE2]
  assign fault = !hit || misaligned || (reqFetch && inNoExec);

  // read data comes back on its lanes and leaves right-justified [RULE18]
  assign rdShift = slvRdata >> {slvAddr_r[1:0], 3'h0};
  always_comb begin
    case (slvSize_r)
      SIZE_BYTE: rdData = {24'h00_0000, rdShift[7:0]};
      SIZE_HALF: rdData = {16'h0000, rdShift[15:0]};
      default: rdData = rdShift;
    endcase
  end

  // modified byte for the alias write-back [RULE7]
  assign bbByte = rdShift[7:0];
  always_comb begin
    bbMod = bbByte;
    bbMod[bbBit_r] = bbValue_r;
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (take && !fault) begin
          state_nxt = isAlias ? ST_BB_READ : ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        if (slvReady) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_BB_READ: begin
        if (slvReady) begin
          state_nxt = bbWrite_r ? ST_BB_WRITE : ST_IDLE;
        end
      end
      ST_BB_WRITE: begin
        if (slvReady) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // no new request while the read-modify-write is in flight [RULE7]
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reqReady_r <= 1'b1;
    end else begin
      reqReady_r <= (state_nxt == ST_IDLE);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bbBit_r <= 3'h0;
      bbWrite_r <= 1'b0;
      bbValue_r <= 1'b0;
    end else if (take && isAlias) begin
      bbBit_r <= aliasOff[4:2];
      bbWrite_r <= reqWrite;
      bbValue_r <= reqWdata[0];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      slvSel_r <= '0;
      slvValid_r <= 1'b0;
      slvAddr_r <= 32'h0000_0000;
      slvWrite_r <= 1'b0;
      slvSize_r <= SIZE_BYTE;
      slvByteEn_r <= 4'h0;
      slvWdata_r <= 32'h0000_0000;
      slvLock_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (take && !fault) begin
            slvSel_r <= SelOne << target; // [RULE20]
            slvValid_r <= 1'b1;
            slvAddr_r <= effAddr; // [RULE16]
            slvWrite_r <= reqWrite && !isAlias;
            slvSize_r <= effSize; // [RULE17]
            slvByteEn_r <= byteEn;
            slvWdata_r <= laneData; // [RULE18]
            slvLock_r <= isAlias; // [RULE7]
          end
        end
        ST_ACCESS: begin
          if (slvReady) begin
            slvSel_r <= '0;
            slvValid_r <= 1'b0;
            slvWrite_r <= 1'b0;
          end
        end
        ST_BB_READ: begin
          if (slvReady) begin
            if (bbWrite_r) begin
              // same select, address and lane, still locked [RULE7]
              slvWrite_r <= 1'b1;
              slvWdata_r <= {4{bbMod}};
            end else begin
              slvSel_r <= '0;
              slvValid_r <= 1'b0;
              slvLock_r <= 1'b0;
            end
          end
        end
        ST_BB_WRITE: begin
          if (slvReady) begin
            slvSel_r <= '0;
            slvValid_r <= 1'b0;
            slvWrite_r <= 1'b0;
            slvLock_r <= 1'b0;
          end
        end
        default: begin
          slvSel_r <= '0;
          slvValid_r <= 1'b0;
          slvLock_r <= 1'b0;
        end
      endcase
    end
  end

  // response is a one-cycle pulse; data holds until the next one
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rspValid_r <= 1'b0;
      rspFault_r <= 1'b0;
      rspData_r <= 32'h0000_0000;
    end else begin
      rspValid_r <= 1'b0;
      rspFault_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (take && fault) begin // [RULE2] [RULE19]
            rspValid_r <= 1'b1;
            rspFault_r <= 1'b1;
            rspData_r <= 32'h0000_0000;
          end
        end
        ST_ACCESS: begin
          if (slvReady) begin
            rspValid_r <= 1'b1;
            rspData_r <= slvWrite_r ? 32'h0000_0000 : rdData;
          end
        end
        ST_BB_READ: begin
          if (slvReady && !bbWrite_r) begin
            rspValid_r <= 1'b1;
            rspData_r <= {31'h0000_0000, bbByte[bbBit_r]}; // [RULE5]
          end
        end
        ST_BB_WRITE: begin
          if (slvReady) begin
            rspValid_r <= 1'b1;
            rspData_r <= 32'h0000_0000;
          end
        end
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  sequence s_bbReadDone;
    state_r == ST_BB_READ && slvReady && bbWrite_r;
  endsequence

  sequence s_bbWriteHeld;
    slvLock_r && slvWrite_r && slvValid_r && $stable(slvAddr_r) && $stable(slvSel_r);
  endsequence

  a_fault_no_slave: assert property ( // [RULE2]
    take && fault |=> rspValid_r && rspFault_r && !slvValid_r && reqReady_r)
    else $error("fault request reached a slave or got no fault answer");

  a_flash_select: assert property ( // [RULE3]
    take && !fault && reqAddr <= `FLASH_LAST |=> slvSel_r == (SelOne << TGT_FLASH))
    else $error("flash address did not select flash");

  a_code_reserved: assert property ( // [RULE3]
    take && reqAddr > `FLASH_LAST && reqAddr < `SRAM_BASE |=> rspFault_r)
    else $error("reserved code address did not fault");

  a_sram_select: assert property ( // [RULE4]
    take && !fault && reqAddr >= `SRAM_BASE && reqAddr <= `SRAM_LAST
    |=> slvSel_r == (SelOne << TGT_SRAM))
    else $error("sram address did not select sram");

  a_sram_alias_map: assert property ( // [RULE5]
    take && inSramAlias |=> slvSel_r == (SelOne << TGT_SRAM) && slvLock_r
    && slvAddr_r == `SRAM_BASE + (($past(reqAddr) - `SRAM_ALIAS_BASE) >> 5))
    else $error("sram alias word mapped to the wrong byte");

  a_peri_alias_map: assert property ( // [RULE6]
    take && inPeriAlias && !fault |=> slvAddr_r >= `PERI_BASE
    && slvAddr_r <= `PERI_BB_LAST && slvSize_r == SIZE_BYTE)
    else $error("peripheral alias left the bit-band span");

  a_bb_atomic: assert property ( // [RULE7]
    s_bbReadDone |=> s_bbWriteHeld ##0 !reqReady_r)
    else $error("alias write-back not locked to the read");

  a_wdog_select: assert property ( // [RULE8]
    take && !isAlias && reqAddr >= `WDOG_BASE && reqAddr <= `WDOG_BASE + `WIN_4K_LAST
    && !reqFetch && !misaligned |=> slvSel_r == (SelOne << TGT_WDOG))
    else $error("watchdog window not selected");

  a_gpio_ports: assert property ( // [RULE9]
    take && !fault && reqAddr[31:14] == 18'h10001
    |=> slvSel_r == (SelOne << (TGT_GPIOA + $past(reqAddr[13:12]))))
    else $error("gpio port window selected the wrong port");

  a_one_select: assert property ( // [RULE20]
    slvValid_r |-> $onehot(slvSel_r) && !rspFault_r)
    else $error("slave access without exactly one select");

  a_fetch_noexec: assert property ( // [RULE19]
    take && reqFetch && inNoExec |=> rspValid_r && rspFault_r)
    else $error("fetch from peripheral space did not fault");

  a_byte_lanes: assert property ( // [RULE18]
    take && !fault && !isAlias && reqSize == SIZE_BYTE
    |=> slvByteEn_r == (4'h1 << $past(reqAddr[1:0]))
    && slvWdata_r[7:0] == $past(reqWdata[7:0]))
    else $error("byte write put on the wrong lane");

  a_access_answer: assert property ( // [RULE17]
    state_r == ST_ACCESS && slvReady |=> rspValid_r && !slvValid_r
    ##1 !(rspValid_r && !rspFault_r))
    else $error("completed access not answered in one cycle");
endmodule
`default_nettype wire

// ### tb/slave_model.sv
`timescale 1ns/1ns
`default_nettype none
module slave_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // decoder request
  input wire logic slvValid_r,
  input wire logic [31:0] slvAddr_r,
  input wire logic [3:0] slvByteEn_r,
  // stall length chosen by the bench
  input wire logic [3:0] waitCycles,
  // answer
  output logic slvReady,
  output logic [31:0] slvRdata
);
  logic [3:0] waitCnt_r;
  logic [31:0] lastRdata_r;
  logic [31:0] laneData;

  always_comb begin
    for (int n = 0; n < 4; n++) begin
      // lanes outside the enables carry junk, so a wrong size cannot pass
      laneData[8*n +: 8] = ({slvAddr_r[7:2], 2'b00} + 8'(n)) ^ 8'h5a;
      if (!slvByteEn_r[n]) begin
        laneData[8*n +: 8] = ~laneData[8*n +: 8];
      end
    end
  end

  assign slvReady = slvValid_r && (waitCnt_r >= waitCycles);
  // outside a completing cycle the data lines keep toggling, never a stale match
  assign slvRdata = slvReady ? laneData : ~lastRdata_r;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      waitCnt_r <= 4'h0;
      lastRdata_r <= 32'h0;
    end else begin
      lastRdata_r <= slvRdata;
      if (slvValid_r && slvReady) begin
        waitCnt_r <= 4'h0;
      end else if (slvValid_r) begin
        waitCnt_r <= waitCnt_r + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/system_address_decoder_test.sv
`timescale 1ns/1ns
`default_nettype none
module system_address_decoder_test;
  import addr_dec_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic reqValid = 1'b0;
  logic [31:0] reqAddr = 32'h0;
  logic reqWrite = 1'b0;
  size_e reqSize = SIZE_WORD;
  logic reqFetch = 1'b0;
  logic [31:0] reqWdata = 32'h0;
  logic [3:0] waitCycles = 4'h0;
  logic reqReady_r, rspValid_r, rspFault_r, slvValid_r, slvWrite_r, slvLock_r, slvReady;
  logic [31:0] rspData_r, slvAddr_r, slvWdata_r, slvRdata;
  logic [NumTargets-1:0] slvSel_r, lastSel;
  size_e slvSize_r;
  logic [3:0] slvByteEn_r, lastBe;
  int num_errors = 0;
  int cmp_count = 0;
  int xfers, lat;
  logic gotFault, lockAll, firstRead;
  logic [31:0] gotData, lastAddr, lastWdata;
  size_e lastSize;
  localparam logic [31:0] MemAddr [16] = '{32'h0, 32'h7ffc, 32'h8000, 32'h1fff_fffc,
    32'h2000_0000, 32'h2000_1ffc, 32'h2000_2000, 32'he000_0000, 32'he000_1000,
    32'he000_2ffc, 32'he000_3000, 32'he000_e000, 32'he000_f000, 32'he004_0ffc,
    32'he004_1000, 32'h6000_0000};
  localparam int MemTgt [16] = '{0, 0, -1, -1, 1, 1, -1, 10, 11, 12, -1, 13, -1, 14, -1, -1};
  localparam logic [31:0] PerAddr [12] = '{32'h4000_0ffc, 32'h4000_1000, 32'h4000_4000,
    32'h4000_5ffc, 32'h4000_6000, 32'h4000_7ffc, 32'h4000_8000, 32'h4002_4000,
    32'h4002_5000, 32'h400f_d000, 32'h400f_effc, 32'h400f_f000};
  localparam int PerTgt [12] = '{2, -1, 3, 4, 5, 6, 15, 7, -1, 8, 9, -1};

  always #5 clk_sys = ~clk_sys;

  sys_addr_decoder sys_addr_decoder_inst (.clk_sys(clk_sys), .arst_n(arst_n),
    .reqValid(reqValid), .reqAddr(reqAddr), .reqWrite(reqWrite), .reqSize(reqSize),
    .reqFetch(reqFetch), .reqWdata(reqWdata), .reqReady_r(reqReady_r),
    .rspValid_r(rspValid_r), .rspFault_r(rspFault_r), .rspData_r(rspData_r),
    .slvSel_r(slvSel_r), .slvValid_r(slvValid_r), .slvAddr_r(slvAddr_r),
    .slvWrite_r(slvWrite_r), .slvSize_r(slvSize_r), .slvByteEn_r(slvByteEn_r),
    .slvWdata_r(slvWdata_r), .slvLock_r(slvLock_r), .slvReady(slvReady),
    .slvRdata(slvRdata));
  slave_model slave_model_inst (.clk_sys(clk_sys), .arst_n(arst_n), .slvValid_r(slvValid_r),
    .slvAddr_r(slvAddr_r), .slvByteEn_r(slvByteEn_r), .waitCycles(waitCycles),
    .slvReady(slvReady), .slvRdata(slvRdata));

  function automatic logic [7:0] pat(input logic [31:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction

  task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected data at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // one request held until taken; slave-side traffic is recorded on the way
  task automatic access(input logic [31:0] a, input logic w, input size_e s, input logic f,
                        input logic [31:0] d);
    int n;
    xfers = 0;
    lockAll = 1'b1;
    firstRead = 1'b0;
    gotFault = 1'bx;
    lat = 0;
    reqValid <= 1'b1;
    reqAddr <= a;
    reqWrite <= w;
    reqSize <= s;
    reqFetch <= f;
    reqWdata <= d;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (reqReady_r !== 1'b1 && n < 50);
    @(posedge clk_sys);
    reqValid <= 1'b0;
    n = 0;
    while (n < 100 && lat == 0) begin
      @(negedge clk_sys);
      n++;
      if (slvValid_r === 1'b1 && slvReady === 1'b1) begin
        if (xfers == 0) begin
          firstRead = !slvWrite_r;
        end
        xfers++;
        lockAll &= slvLock_r;
        lastSel = slvSel_r;
        lastAddr = slvAddr_r;
        lastBe = slvByteEn_r;
        lastWdata = slvWdata_r;
        lastSize = slvSize_r;
      end
      if (rspValid_r === 1'b1) begin
        gotFault = rspFault_r;
        gotData = rspData_r;
        lat = n;
      end
    end
    // a request never taken or never answered counts as a mismatch
    cmp_flag(lat != 0, 1'b1);
    @(posedge clk_sys);
  endtask

  task automatic check_map(input logic [31:0] a, input int tgt);
    access(a, 1'b0, SIZE_WORD, 1'b0, 32'h0);
    cmp_flag(gotFault, tgt < 0);
    if (tgt >= 0) begin
      cmp_data(32'(lastSel), 32'h1 << tgt);
      cmp_data(lastAddr, a);
      cmp_data(gotData, {pat(a + 3), pat(a + 2), pat(a + 1), pat(a)});
    end else begin
      cmp_data(32'(xfers), 32'h0);
      cmp_data(gotData, 32'h0);
    end
  endtask

  task automatic test_map;
    for (int i = 0; i < 16; i++) begin
      check_map(MemAddr[i], MemTgt[i]);
    end
    for (int i = 0; i < 12; i++) begin
      check_map(PerAddr[i], PerTgt[i]);
    end
  endtask

  task automatic test_lanes;
    access(32'h2000_0001, 1'b0, SIZE_BYTE, 1'b0, 32'h0);
    cmp_data(gotData, {24'h0, pat(32'h1)});
    cmp_data({28'h0, lastBe}, 32'h2);
    access(32'h2000_0002, 1'b0, SIZE_HALF, 1'b0, 32'h0);
    cmp_data(gotData, {16'h0, pat(32'h3), pat(32'h2)});
    cmp_data({28'h0, lastBe}, 32'hc);
    cmp_data(32'(lastSize), 32'(SIZE_HALF));
    access(32'h2000_0003, 1'b1, SIZE_BYTE, 1'b0, 32'hab);
    cmp_data(lastWdata & 32'hff00_0000, 32'hab00_0000);
    cmp_data({28'h0, lastBe}, 32'h8);
    access(32'h2000_0006, 1'b1, SIZE_HALF, 1'b0, 32'hbeef);
    cmp_data(lastWdata & 32'hffff_0000, 32'hbeef_0000);
    access(32'h2000_0004, 1'b1, SIZE_WORD, 1'b0, 32'h1122_3344);
    cmp_data(lastWdata, 32'h1122_3344);
    cmp_data({28'h0, lastBe}, 32'hf);
    access(32'h2000_0001, 1'b0, SIZE_HALF, 1'b0, 32'h0);
    cmp_flag(gotFault, 1'b1);
    access(32'h2000_0000, 1'b0, size_e'(2'h3), 1'b0, 32'h0);
    cmp_flag(gotFault, 1'b1);
  endtask

  task automatic test_alias;
    access(32'h2200_0200, 1'b1, SIZE_WORD, 1'b0, 32'h1);
    cmp_data(32'(xfers), 32'h2);
    cmp_flag(firstRead & lockAll, 1'b1);
    cmp_data(lastAddr, 32'h2000_0010);
    cmp_data(lastWdata, 32'h4b4b_4b4b);
    cmp_data(32'(lastSize), 32'(SIZE_BYTE));
    access(32'h2200_0204, 1'b0, SIZE_WORD, 1'b0, 32'h0);
    cmp_data(gotData, 32'h1);
    access(32'h2200_0208, 1'b0, SIZE_WORD, 1'b0, 32'h0);
    cmp_data(gotData, 32'h0);
    access(32'h4208_0004, 1'b1, SIZE_WORD, 1'b0, 32'h0);
    cmp_data(32'(lastSel), 32'h1 << TGT_GPIOA);
    cmp_data(lastAddr, 32'h4000_4000);
    cmp_data(lastWdata, 32'h5858_5858);
    access(32'h4202_0000, 1'b0, SIZE_WORD, 1'b0, 32'h0);
    cmp_flag(gotFault, 1'b1);
  endtask

  task automatic test_fetch;
    access(32'h4000_4000, 1'b0, SIZE_WORD, 1'b1, 32'h0);
    cmp_flag(gotFault, 1'b1);
    access(32'h5fff_fffc, 1'b0, SIZE_WORD, 1'b1, 32'h0);
    cmp_flag(gotFault, 1'b1);
    access(32'h0000_0100, 1'b0, SIZE_WORD, 1'b1, 32'h0);
    cmp_flag(gotFault, 1'b0);
  endtask

  task automatic test_stall;
    waitCycles <= 4'h5;
    access(32'h2000_0008, 1'b0, SIZE_WORD, 1'b0, 32'h0);
    cmp_data(gotData, {pat(32'hb), pat(32'ha), pat(32'h9), pat(32'h8)});
    cmp_data(32'(lat), 32'h7);
    waitCycles <= 4'h0;
  endtask

  // reset dropped while a stalled access is still open, then a request at the first edge
  task automatic test_reset;
    waitCycles <= 4'hf;
    reqValid <= 1'b1;
    reqAddr <= 32'h2000_0000;
    reqWrite <= 1'b0;
    reqSize <= SIZE_WORD;
    reqFetch <= 1'b0;
    @(posedge clk_sys);
    reqValid <= 1'b0;
    @(negedge clk_sys);
    cmp_flag(slvValid_r, 1'b1);
    @(posedge clk_sys);
    arst_n <= 1'b0;
    @(negedge clk_sys);
    cmp_flag(slvValid_r | rspValid_r | slvLock_r, 1'b0);
    cmp_flag(reqReady_r, 1'b1);
    cmp_data(32'(slvSel_r), 32'h0);
    @(posedge clk_sys);
    arst_n <= 1'b1;
    waitCycles <= 4'h0;
    check_map(32'h2000_0000, 1);
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    arst_n <= 1'b1;
    test_map;
    test_lanes;
    test_alias;
    test_fetch;
    test_stall;
    test_reset;
    print_verdict;
  end

  initial begin
    // about forty-five short accesses; this leaves a wide margin
    #200000;
    num_errors++;
    print_verdict;
  end
endmodule
`default_nettype wire
